/* verilog/fcct_defines.vh */
// Register map, field positions, codes and reset values of the timer.
// Assumes an 8-bit register port and one 50 MHz clock.
//
// Behaviour
// - On compare apply channel action: off, toggle, drive low, drive high
// - Nonzero action code turns channel pin into driven compare output
// - Edge select: off, rising only, falling only, either edge
// - Channel interrupt request only while flag set and enable bit is one
// - Overflow interrupt request while overflow flag set and enable is one
// - Counter-reset-on-ch3 bit makes channel-3 compare reset the counter
// - With reset on ch3 and compare value zero, counter stays at zero
// - With reset on ch3 and compare value all ones, no overflow flag
// - New prescale select takes effect when all prescaler stages are zero
// - Counting clock is bus clock divided by two to the select value
// - Capture or compare event sets that channel's event flag
// - Writing one clears a channel flag, writing zero leaves it
// - Fast clear: capture value read or compare value write clears flag
// - Writing one to overflow flag bit clears it
// - Fast clear: any counter access clears the overflow flag
// - Counter wrap from all ones to zero sets the overflow flag
// - Timer counts only while the timer enable bit is one
`ifndef FCCT_DEFINES_VH
`define FCCT_DEFINES_VH

// ********************************************************************
// Register offsets
// ********************************************************************
`define FCCT_ADDR_MODE     8'hc0
`define FCCT_ADDR_CNT_HI   8'hc4
`define FCCT_ADDR_CNT_LO   8'hc5
`define FCCT_ADDR_SYS1     8'hc6
`define FCCT_ADDR_ACTION   8'hc8
`define FCCT_ADDR_EDGE     8'hc9
`define FCCT_ADDR_IRQEN    8'hca
`define FCCT_ADDR_OVFFLG   8'hcb
`define FCCT_ADDR_FLAGS    8'hcc
`define FCCT_ADDR_SYS2     8'hcd
`define FCCT_ADDR_TC0_HI   8'hce
`define FCCT_TC_STRIDE     8'h02

// ********************************************************************
// Field positions
// ********************************************************************
`define FCCT_SYS1_ENABLE   7
`define FCCT_SYS1_FASTCLR  4
`define FCCT_SYS2_OVFIE    7
`define FCCT_SYS2_CRE      3
`define FCCT_SYS2_PS_MSB   2
`define FCCT_SYS2_PS_LSB   0
`define FCCT_OVF_BIT       7

// ********************************************************************
// Codes
// ********************************************************************
`define FCCT_ACT_OFF       2'b00
`define FCCT_ACT_TOGGLE    2'b01
`define FCCT_ACT_LOW       2'b10
`define FCCT_ACT_HIGH      2'b11
`define FCCT_CNT_MAX       16'hffff
`define FCCT_PS_ALL        7'h7f

// ********************************************************************
// Reset values
// ********************************************************************
`define FCCT_RST_REG8      8'h00
`define FCCT_RST_REG16     16'h0000

`endif

/* verilog/fcct_prescaler.v */
// Prescaler stages that make the counting tick from the bus clock.
// Assumes run_i and sel_i come from logic on the same clock.
`timescale 1ns/1ps
`include "fcct_defines.vh"

module fcct_prescaler (
   input  wire       clock_i,
   input  wire       sys_rst_i,
   input  wire       run_i,
   input  wire [2:0] sel_i,
   output wire       tick_o
);

   reg  [6:0] div_r;
   reg  [2:0] sel_r;
   wire [6:0] mask;

   // ********************************************************************
   // Stage counter and select update
   // ********************************************************************
   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         div_r <= 7'h00;
         sel_r <= 3'h0;
      end else begin
         if (run_i) begin
            div_r <= div_r + 7'h01;
         end else begin
            div_r <= 7'h00;
         end
         if (div_r == 7'h00) begin
            sel_r <= sel_i;
         end
      end
   end

   assign mask   = ~(`FCCT_PS_ALL << sel_r) & `FCCT_PS_ALL;
   assign tick_o = run_i & ((div_r & mask) == mask);

endmodule // fcct_prescaler

/* verilog/fcct_timer.v */
// Four-channel capture/compare timer with its control and status logic.
// Assumes an 8-bit register port on clock_i and asynchronous pin inputs.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "fcct_defines.vh"

module fcct_timer (
   input  wire       clock_i,
   input  wire       sys_rst_i,
   input  wire [7:0] reg_addr_i,
   input  wire [7:0] reg_wdata_i,
   input  wire       reg_wr_i,
   input  wire       reg_rd_i,
   output wire [7:0] reg_rdata_o,
   input  wire [3:0] cap_pin_i,
   output wire [3:0] cmp_pin_o,
   output wire [3:0] cmp_pin_oe_o,
   output wire [3:0] chan_irq_o,
   output wire       ovf_irq_o
);

   // ********************************************************************
   // Registers
   // ********************************************************************
   reg  [7:0]  mode_r;
   reg  [7:0]  sys1_r;
   reg  [7:0]  action_r;
   reg  [7:0]  edge_r;
   reg  [7:0]  irqen_r;
   reg  [7:0]  sys2_r;
   reg  [3:0]  flags_r;
   reg  [3:0]  flags_nxt;
   reg         ovf_r;
   reg         ovf_nxt;
   reg  [15:0] cnt_r;
   reg  [15:0] cnt_nxt;
   reg  [7:0]  rdata_r;
   reg  [7:0]  rdata_nxt;
   reg  [3:0]  chan_irq_r;
   reg         ovf_irq_r;

   wire        tick;
   wire        timer_on;
   wire        fast_clr;
   wire        ovf_ie;
   wire        cnt_rst_en;
   wire [3:0]  chan_ev;
   wire [3:0]  cmp_ev;
   wire [3:0]  fast_flag_clr;
   wire [3:0]  flag_w1c;
   wire        ovf_w1c;
   wire        cnt_hit;
   wire        ch3_reset;
   wire        ovf_set;
   wire [7:0]  tc_rd [0:4];
   wire        sel_mode;
   wire        sel_cnt_hi;
   wire        sel_cnt_lo;
   wire        sel_sys1;
   wire        sel_action;
   wire        sel_edge;
   wire        sel_irqen;
   wire        sel_ovf;
   wire        sel_flags;
   wire        sel_sys2;

   assign timer_on   = sys1_r[`FCCT_SYS1_ENABLE];
   assign fast_clr   = sys1_r[`FCCT_SYS1_FASTCLR];
   assign ovf_ie     = sys2_r[`FCCT_SYS2_OVFIE];
   assign cnt_rst_en = sys2_r[`FCCT_SYS2_CRE];
   assign tc_rd[0]   = 8'h00;

   // ********************************************************************
   // Register address decode
   // ********************************************************************
   assign sel_mode   = (reg_addr_i == `FCCT_ADDR_MODE);
   assign sel_cnt_hi = (reg_addr_i == `FCCT_ADDR_CNT_HI);
   assign sel_cnt_lo = (reg_addr_i == `FCCT_ADDR_CNT_LO);
   assign sel_sys1   = (reg_addr_i == `FCCT_ADDR_SYS1);
   assign sel_action = (reg_addr_i == `FCCT_ADDR_ACTION);
   assign sel_edge   = (reg_addr_i == `FCCT_ADDR_EDGE);
   assign sel_irqen  = (reg_addr_i == `FCCT_ADDR_IRQEN);
   assign sel_ovf    = (reg_addr_i == `FCCT_ADDR_OVFFLG);
   assign sel_flags  = (reg_addr_i == `FCCT_ADDR_FLAGS);
   assign sel_sys2   = (reg_addr_i == `FCCT_ADDR_SYS2);

   // ********************************************************************
   // Prescaler
   // ********************************************************************
   fcct_prescaler u_prescaler (
      .clock_i   (clock_i),
      .sys_rst_i (sys_rst_i),
      .run_i     (timer_on),
      .sel_i     (sys2_r[`FCCT_SYS2_PS_MSB:`FCCT_SYS2_PS_LSB]),
      .tick_o    (tick)
   );

   // ********************************************************************
   // Per-channel capture, compare and pin logic
   // ********************************************************************
   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_chan
         localparam integer CH_OFS_I = 2 * i;
         localparam [7:0]   CH_OFS   = CH_OFS_I[7:0];
         reg  [1:0]  sync_r;
         reg         prev_r;
         reg  [15:0] tc_r;
         reg         line_r;
         reg         line_nxt;
         reg         oe_r;
         wire        pin_s;
         wire        rise;
         wire        fall;
         wire [1:0]  edge_sel;
         wire [1:0]  act;
         wire        is_cmp;
         wire        hit_hi;
         wire        hit_lo;
         wire        cap_ev;
         wire [7:0]  rd_val;

         assign pin_s    = sync_r[1];
         assign rise     = pin_s & ~prev_r;
         assign fall     = ~pin_s & prev_r;
         assign edge_sel = edge_r[2*i+1:2*i];
         assign act      = action_r[2*i+1:2*i];
         assign is_cmp   = mode_r[i];
         assign hit_hi   = (reg_addr_i == (`FCCT_ADDR_TC0_HI + CH_OFS));
         assign hit_lo   = (reg_addr_i ==
                            (`FCCT_ADDR_TC0_HI + CH_OFS + 8'h01));
         assign cap_ev   = ~is_cmp & timer_on &
                           ((edge_sel[0] & rise) |
                            (edge_sel[1] & fall));
         assign cmp_ev[i]  = is_cmp & tick & (cnt_r == tc_r);
         assign chan_ev[i] = cap_ev | cmp_ev[i];
         assign fast_flag_clr[i] = fast_clr & (hit_hi | hit_lo) &
                                   ((reg_rd_i & ~is_cmp) |
                                    (reg_wr_i & is_cmp));
         assign rd_val = hit_hi ? tc_r[15:8] :
                         (hit_lo ? tc_r[7:0] : 8'h00);
         assign tc_rd[i+1]      = tc_rd[i] | rd_val;
         assign cmp_pin_o[i]    = line_r;
         assign cmp_pin_oe_o[i] = oe_r;

         always @* begin
            line_nxt = line_r;
            if (cmp_ev[i]) begin
               case (act)
                  `FCCT_ACT_TOGGLE: line_nxt = ~line_r;
                  `FCCT_ACT_LOW:    line_nxt = 1'b0;
                  `FCCT_ACT_HIGH:   line_nxt = 1'b1;
                  default:          line_nxt = line_r;
               endcase
            end
         end

         always @(posedge clock_i) begin
            if (sys_rst_i) begin
               sync_r <= 2'b00;
               prev_r <= 1'b0;
               tc_r   <= `FCCT_RST_REG16;
               line_r <= 1'b0;
               oe_r   <= 1'b0;
            end else begin
               sync_r <= {sync_r[0], cap_pin_i[i]};
               prev_r <= pin_s;
               if (cap_ev) begin
                  tc_r <= cnt_r;
               end else if (reg_wr_i & is_cmp & hit_hi) begin
                  tc_r[15:8] <= reg_wdata_i;
               end else if (reg_wr_i & is_cmp & hit_lo) begin
                  tc_r[7:0] <= reg_wdata_i;
               end
               line_r <= line_nxt;
               oe_r <= |act;
            end
         end
      end
   endgenerate

   // ********************************************************************
   // Free-running counter and overflow
   // ********************************************************************
   assign ch3_reset = cnt_rst_en & cmp_ev[3];
   assign ovf_set   = tick & (cnt_r == `FCCT_CNT_MAX) & ~ch3_reset;

   always @* begin
      cnt_nxt = cnt_r;
      if (tick) begin
         if (ch3_reset) begin
            cnt_nxt = `FCCT_RST_REG16;
         end else begin
            cnt_nxt = cnt_r + 16'h0001;
         end
      end
   end

   // ********************************************************************
   // Flag update, set wins over clear
   // ********************************************************************
   assign cnt_hit  = sel_cnt_hi | sel_cnt_lo;
   assign flag_w1c = (reg_wr_i && sel_flags) ?
                     reg_wdata_i[3:0] : 4'h0;
   assign ovf_w1c  = reg_wr_i && sel_ovf &&
                     reg_wdata_i[`FCCT_OVF_BIT];

   always @* begin
      flags_nxt = (flags_r & ~(flag_w1c | fast_flag_clr)) | chan_ev;
      ovf_nxt   = (ovf_r & ~(ovf_w1c |
                   (fast_clr & cnt_hit & (reg_rd_i | reg_wr_i))))
                  | ovf_set;
   end

   // ********************************************************************
   // Register write port
   // ********************************************************************
   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         mode_r   <= `FCCT_RST_REG8;
         sys1_r   <= `FCCT_RST_REG8;
         action_r <= `FCCT_RST_REG8;
         edge_r   <= `FCCT_RST_REG8;
         irqen_r  <= `FCCT_RST_REG8;
         sys2_r   <= `FCCT_RST_REG8;
      end else if (reg_wr_i) begin
         if (sel_mode) begin
            mode_r <= {4'h0, reg_wdata_i[3:0]};
         end else if (sel_sys1) begin
            sys1_r <= reg_wdata_i & 8'h90;
         end else if (sel_action) begin
            action_r <= reg_wdata_i;
         end else if (sel_edge) begin
            edge_r <= reg_wdata_i;
         end else if (sel_irqen) begin
            irqen_r <= {4'h0, reg_wdata_i[3:0]};
         end else if (sel_sys2) begin
            sys2_r <= reg_wdata_i & 8'h8f;
         end
      end
   end

   // ********************************************************************
   // State, counter and interrupt requests
   // ********************************************************************
   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         cnt_r      <= `FCCT_RST_REG16;
         flags_r    <= 4'h0;
         ovf_r      <= 1'b0;
         chan_irq_r <= 4'h0;
         ovf_irq_r  <= 1'b0;
      end else begin
         cnt_r      <= cnt_nxt;
         flags_r    <= flags_nxt;
         ovf_r      <= ovf_nxt;
         chan_irq_r <= flags_r & irqen_r[3:0];
         ovf_irq_r  <= ovf_r & ovf_ie;
      end
   end

   // ********************************************************************
   // Register read port
   // ********************************************************************
   always @* begin
      rdata_nxt = tc_rd[4];
      if (sel_mode) begin
         rdata_nxt = mode_r;
      end else if (sel_cnt_hi) begin
         rdata_nxt = cnt_r[15:8];
      end else if (sel_cnt_lo) begin
         rdata_nxt = cnt_r[7:0];
      end else if (sel_sys1) begin
         rdata_nxt = sys1_r;
      end else if (sel_action) begin
         rdata_nxt = action_r;
      end else if (sel_edge) begin
         rdata_nxt = edge_r;
      end else if (sel_irqen) begin
         rdata_nxt = irqen_r;
      end else if (sel_ovf) begin
         rdata_nxt = {ovf_r, 7'h00};
      end else if (sel_flags) begin
         rdata_nxt = {4'h0, flags_r};
      end else if (sel_sys2) begin
         rdata_nxt = sys2_r;
      end
   end

   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         rdata_r <= 8'h00;
      end else if (reg_rd_i) begin
         rdata_r <= rdata_nxt;
      end else begin
         rdata_r <= 8'h00;
      end
   end

   assign reg_rdata_o = rdata_r;
   assign chan_irq_o  = chan_irq_r;
   assign ovf_irq_o   = ovf_irq_r;

endmodule // fcct_timer

/* verilog/fcct_timer_end.v */
// Holds no logic; the timer lives in fcct_timer.v.

/* sim/fcct_timer_checker.sv */
// Properties of the timer seen at its top module ports.
// Assumes a bind onto fcct_timer and a single clock domain.
`timescale 1ns/1ps
module fcct_timer_checker (
   input wire       clock_i,
   input wire       sys_rst_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire       reg_wr_i,
   input wire       reg_rd_i,
   input wire [7:0] reg_rdata_o,
   input wire [3:0] cap_pin_i,
   input wire [3:0] cmp_pin_o,
   input wire [3:0] cmp_pin_oe_o,
   input wire [3:0] chan_irq_o,
   input wire       ovf_irq_o
);
   // ********
   // Shadows
   // ********
   logic [7:0] act_r, ien_r, sys1_r, sys2_r;
   logic [1:0] off_cnt_r;
   wire        acc = reg_wr_i | reg_rd_i;
   wire  [3:0] nz = {|act_r[7:6], |act_r[5:4], |act_r[3:2], |act_r[1:0]};
   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         act_r <= 8'h00;
         ien_r <= 8'h00;
         sys1_r <= 8'h00;
         sys2_r <= 8'h00;
      end else if (reg_wr_i) begin
         if (reg_addr_i == 8'hc8) act_r <= reg_wdata_i;
         if (reg_addr_i == 8'hca) ien_r <= reg_wdata_i;
         if (reg_addr_i == 8'hc6) sys1_r <= reg_wdata_i;
         if (reg_addr_i == 8'hcd) sys2_r <= reg_wdata_i;
      end
   end
   always @(posedge clock_i) begin
      if (sys_rst_i || sys1_r[7]) off_cnt_r <= 2'd0;
      else if (off_cnt_r != 2'd3) off_cnt_r <= off_cnt_r + 2'd1;
   end
   // ***********
   // Properties
   // ***********
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   a_oe_follows_act:
      assert property (!$past(sys_rst_i) |-> cmp_pin_oe_o == $past(nz))
      else $error("pin enable differs from action code");
   a_reset_clean:
      assert property ($fell(sys_rst_i) |-> cmp_pin_oe_o == 4'h0 &&
         chan_irq_o == 4'h0 && !ovf_irq_o)
      else $error("outputs not clear after reset");
   a_chan_gate:
      assert property (!$past(sys_rst_i) |->
         (chan_irq_o & ~$past(ien_r[3:0])) == 4'h0)
      else $error("channel request while disabled");
   a_ovf_gate:
      assert property (ovf_irq_o && !$past(sys_rst_i) |-> $past(sys2_r[7]))
      else $error("overflow request while disabled");
   a_irq_held:
      assert property (!$past(acc) |=>
         (chan_irq_o & $past(chan_irq_o)) == $past(chan_irq_o))
      else $error("channel request dropped without access");
   a_high_holds:
      assert property (act_r[5:4] == 2'b11 && cmp_pin_o[2] |=> cmp_pin_o[2])
      else $error("drive high code let line fall");
   a_low_holds:
      assert property (act_r[3:2] == 2'b10 && !cmp_pin_o[1] |=> !cmp_pin_o[1])
      else $error("drive low code let line rise");
   a_quiet_off:
      assert property (off_cnt_r == 2'd3 && $past(sys2_r[7]) &&
         $past(sys2_r[7], 2) |-> !$rose(ovf_irq_o))
      else $error("overflow while timer stopped");
endmodule // fcct_timer_checker
bind fcct_timer fcct_timer_checker i_chk (
   .clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .cap_pin_i(cap_pin_i),
   .cmp_pin_o(cmp_pin_o), .cmp_pin_oe_o(cmp_pin_oe_o),
   .chan_irq_o(chan_irq_o), .ovf_irq_o(ovf_irq_o));

/* sim/fcct_host.sv */
// Host model that masters the timer register port.
// Assumes the bench calls wr and rd by hierarchical name.
`timescale 1ns/1ps
module fcct_host (
   input  wire        clock_i,
   input  wire  [7:0] rdata_i,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   output logic       wr_o,
   output logic       rd_o
);
   // ***********
   // Bus cycles
   // ***********
   initial begin
      addr_o = 8'h00;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clock_i);
      wr_o <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clock_i);
      rd_o <= 1'b0;
      @(posedge clock_i);
      d = rdata_i;
   endtask
endmodule // fcct_host

/* sim/fcct_timer_bench.sv */
// Self-checking bench for the four-channel timer.
// Assumes fcct_host and the bound checker are compiled first.
`timescale 1ns/1ps
module fcct_timer_bench;
   // **********
   // Harness
   // **********
   localparam int LIMIT = 90000;
   logic       clock_i = 1'b0;
   logic       sys_rst_i = 1'b1;
   logic [3:0] cap_pin = 4'h0;
   wire  [7:0] addr, wdata, rdata;
   wire        bus_wr, bus_rd, ovf;
   wire  [3:0] pin, oe, irq;
   logic [7:0] d, d2;
   int         fail_count = 0;
   int         cmp_count = 0;
   int         cyc = 0;
   fcct_host i_host (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr),
      .wdata_o(wdata), .wr_o(bus_wr), .rd_o(bus_rd));
   fcct_timer i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(bus_wr),
      .reg_rd_i(bus_rd), .reg_rdata_o(rdata), .cap_pin_i(cap_pin),
      .cmp_pin_o(pin), .cmp_pin_oe_o(oe), .chan_irq_o(irq),
      .ovf_irq_o(ovf));
   always #10 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         fail_count++;
         summarize;
      end
   end
   task summarize;
      if (fail_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task chk(input string n, input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task rchk(input logic [7:0] a, input logic [7:0] e, input string n);
      i_host.rd(a, d);
      chk(n, d, e);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      i_host.wr(a, v);
   endtask
   // **********
   // Scenarios
   // **********
   task t_reset;
      rchk(8'hc8, 8'h00, "reset action");
      rchk(8'hcd, 8'h00, "reset sys two");
      rchk(8'hcc, 8'h00, "reset flags");
      rchk(8'hca, 8'h00, "reset irq enables");
      rchk(8'hc9, 8'h00, "reset edge select");
      rchk(8'hc6, 8'h00, "reset sys one");
      chk("reset enables", {4'h0, oe}, 8'h00);
      rchk(8'he0, 8'h00, "unmapped");
      wr(8'hc9, 8'he4);
      rchk(8'hc9, 8'he4, "edge select");
      wr(8'hca, 8'hff);
      rchk(8'hca, 8'h0f, "irq enables");
      wr(8'hca, 8'h00);
      wr(8'hcc, 8'hff);
      rchk(8'hcc, 8'h00, "flags idle");
   endtask
   task t_reload;
      wr(8'hc0, 8'h08);
      wr(8'hcd, 8'h08);
      wr(8'hc6, 8'h80);
      repeat (20) @(posedge clock_i);
      rchk(8'hc5, 8'h00, "count held");
      wr(8'hd5, 8'h05);
      repeat (6) begin
         i_host.rd(8'hc5, d);
         chk("count bound", {7'h0, d <= 8'h05}, 8'h01);
      end
      wr(8'hc6, 8'h00);
      wr(8'hcd, 8'h00);
   endtask
   task t_compare;
      wr(8'hcc, 8'h0f);
      wr(8'hc0, 8'h0f);
      wr(8'hc8, 8'h39);
      repeat (3) @(posedge clock_i);
      chk("pin enables", {4'h0, oe}, 8'h07);
      for (int i = 0; i < 4; i++) wr(8'hcf + 8'(2 * i), 8'h10);
      wr(8'hca, 8'h05);
      wr(8'hc6, 8'h80);
      repeat (40) @(posedge clock_i);
      chk("lines", {4'h0, pin}, 8'h05);
      rchk(8'hcc, 8'h0f, "compare flags");
      chk("requests", {4'h0, irq}, 8'h05);
      wr(8'hcc, 8'h01);
      wr(8'hcc, 8'h00);
      rchk(8'hcc, 8'h0e, "flag clear");
      chk("request drop", {4'h0, irq}, 8'h04);
   endtask
   task t_capture;
      wr(8'hc0, 8'h00);
      wr(8'hcc, 8'h0f);
      cap_pin <= 4'hf;
      repeat (8) @(posedge clock_i);
      rchk(8'hcc, 8'h0a, "rising capture");
      wr(8'hcc, 8'h0f);
      cap_pin <= 4'h0;
      repeat (8) @(posedge clock_i);
      rchk(8'hcc, 8'h0c, "falling capture");
      wr(8'hc6, 8'h90);
      i_host.rd(8'hd4, d);
      rchk(8'hcc, 8'h04, "fast clear");
   endtask
   task t_overflow;
      wr(8'hcd, 8'h80);
      for (int i = 0; i < 70000 && ovf !== 1'b1; i++) @(posedge clock_i);
      chk("ovf request", {7'h0, ovf}, 8'h01);
      rchk(8'hcb, 8'h80, "ovf flag");
      i_host.rd(8'hc4, d);
      rchk(8'hcb, 8'h00, "ovf fast clear");
      chk("ovf request low", {7'h0, ovf}, 8'h00);
   endtask
   task t_prescale;
      wr(8'hcd, 8'h87);
      repeat (128) @(posedge clock_i);
      i_host.rd(8'hc5, d);
      repeat (512) @(posedge clock_i);
      i_host.rd(8'hc5, d2);
      d2 = d2 - d;
      chk("div 128", {7'h0, d2 >= 8'h03 && d2 <= 8'h05}, 8'h01);
      wr(8'hc6, 8'h10);
      i_host.rd(8'hc5, d);
      repeat (300) @(posedge clock_i);
      rchk(8'hc5, d, "count stopped");
      chk("ovf idle", {7'h0, ovf}, 8'h00);
   endtask
   initial begin
      repeat (8) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      t_reset;
      t_reload;
      t_compare;
      t_capture;
      t_overflow;
      t_prescale;
      summarize;
   end
endmodule // fcct_timer_bench
